/* inc/tilt_pkg.sv */
// constants for the tilt alarm and report framer: register map, formats, frame layout
// assumes a 16-bit register port and byte-wide transmit stream beside it
package tilt_pkg;

  localparam int AW = 4;
  localparam int DW = 16;

  localparam logic [3:0] A_CMD  = 4'h0;
  localparam logic [3:0] A_FMT  = 4'h1;
  localparam logic [3:0] A_AVGN = 4'h2;
  localparam logic [3:0] A_HYST = 4'h3;
  localparam logic [3:0] A_XP   = 4'h4;
  localparam logic [3:0] A_XN   = 4'h5;
  localparam logic [3:0] A_YP   = 4'h6;
  localparam logic [3:0] A_YN   = 4'h7;
  localparam logic [3:0] A_SER  = 4'h8;
  localparam logic [3:0] A_STAT = 4'h9;
  localparam logic [3:0] A_AVX  = 4'hA;
  localparam logic [3:0] A_AVY  = 4'hB;
  localparam logic [3:0] A_AVT  = 4'hC;

  localparam int CMD_LIMITS = 0;
  localparam int CMD_ZERO   = 1;
  localparam int CMD_READ   = 2;
  localparam int CMD_ON     = 3;
  localparam int CMD_OFF    = 4;
  localparam int CMD_FZERO  = 5;

  typedef enum logic [2:0] {
    simple_text_format    = 3'h0,
    nmea_xdr_format       = 3'h1,
    alt_nmea_format       = 3'h2,
    pitch_roll_format     = 3'h3,
    compact_binary_format = 3'h4
  } fmt_e;

  localparam logic [9:0]  AVGN_RST = 10'h001;
  localparam logic [15:0] AVGN_MAX = 16'h03E8;
  localparam logic [15:0] HYST_RST = 16'h0000;

  localparam logic [7:0]  SYNC_A   = 8'h55;
  localparam logic [7:0]  SYNC_B   = 8'hAA;
  localparam logic [7:0]  CK_MASK  = 8'hFF;
  localparam logic [5:0]  BIN_LAST = 6'h0A;
  localparam logic [10:0] MDEG_Q16 = 11'h717;
  localparam int          TEMP_SH  = 2;

  localparam logic [7:0] PH_X = 8'h78;
  localparam logic [7:0] PH_Y = 8'h79;
  localparam logic [7:0] PH_T = 8'h74;
  localparam logic [7:0] PH_S = 8'h73;
  localparam logic [7:0] PH_H = 8'h68;
  localparam logic [7:0] CH_DASH = 8'h2D;
  localparam logic [7:0] CH_DOT  = 8'h2E;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_N    = 8'h4E;
  localparam logic [7:0] CH_0    = 8'h30;

  // lower case letters mark fields; D marks degree units
  localparam int LEN_SIM = 10;
  localparam int LEN_XDR = 36;
  localparam int LEN_ALT = 38;
  localparam int LEN_PR  = 9;
  localparam logic [8*LEN_SIM-1:0] TXT_SIM = "$x,y,t,s\r\n";
  localparam logic [8*LEN_XDR-1:0] TXT_XDR = "$YXXDR,A,y,D,N,A,x,D,E,C,t,C,T-s*h\r\n";
  localparam logic [8*LEN_ALT-1:0] TXT_ALT = "$PASHS,XDR,A,y,D,N,A,x,D,E,C,t,C,T-s\r\n";
  localparam logic [8*LEN_PR-1:0]  TXT_PR  = "$PyRx*h\r\n";

endpackage

/* logic/tilt_divider.sv */
// sequential restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse while idle; den must be nonzero
`timescale 1ns/1ps
module tilt_divider #(
  parameter int W = 26
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] den_i,
  output logic              done_o,
  output logic [W-1:0]      quo_o,
  output logic [W-1:0]      rem_o
);
  localparam int CW = $clog2(W + 1);

  if (W < 8) begin : g_bad_width
    $error("divider width too small");
  end

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [CW-1:0] cnt;
    logic [W-1:0]  den;
    logic [W-1:0]  quo;
    logic [W-1:0]  rem;
  } div_s;

  div_s       s;
  div_s       next_s;
  logic [W:0] r2;

  always_comb begin
    next_s      = s;
    next_s.done = 1'h0;
    // one spare bit keeps the trial subtraction from wrapping
    r2          = {s.rem, s.quo[W-1]};
    if (start_i) begin
      next_s.busy = 1'h1;
      next_s.cnt  = CW'(W);
      next_s.den  = den_i;
      next_s.quo  = num_i;
      next_s.rem  = '0;
    end else if (s.busy) begin
      if (r2 >= {1'h0, s.den}) begin
        next_s.rem = W'(r2 - {1'h0, s.den});
        next_s.quo = {s.quo[W-2:0], 1'h1};
      end else begin
        next_s.rem = r2[W-1:0];
        next_s.quo = {s.quo[W-2:0], 1'h0};
      end
      next_s.cnt = s.cnt - CW'(1);
      if (s.cnt == CW'(1)) begin
        next_s.busy = 1'h0;
        next_s.done = 1'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done_o = s.done;
  assign quo_o  = s.quo;
  assign rem_o  = s.rem;
endmodule

/* logic/tilt_alarm_and_report_framer.sv */
// tilt alarm with hysteresis plus text and binary report framer
// assumes samples and the transmit handshake are synchronous to MCLK_I
`timescale 1ns/1ps
// What this block does
// - alarm goes high when tilt exceeds the positive limit.
// - alarm also goes high below the negative limit if that limit is positive.
// - a negative limit of zero or less is ignored.
// - one hysteresis value applies to every limit comparison.
// - alarm tilt is measured from the captured zero, else the factory zero.
// - four limits are committed together by one command and stored.
// - a single-reading command yields exactly one report in the chosen format.
// - each reading is the average of a programmable number of samples.
// - simple format is dollar, X, Y, temperature, serial, CR LF.
// - transducer format sends Y, X, temperature, serial, then star and checksum.
// - alternate sentence sends same fields, other header, no checksum.
// - pitch-roll format sends P then Y, R then X, star and checksum.
// - binary frame opens with sync bytes 0x55 then 0xAA.
// - binary tilt is sign-magnitude, sign in bit 15; Y in bytes 4 and 5.
// - binary temperature in bytes 6 and 7 is sign-magnitude.
// - serial number fills bytes 8 and 9.
// - last byte is the sum of bytes 2 to 7 masked to eight bits.
// - binary frame is eleven bytes long.
// - settings hold until software changes them.
// - text unit fields use D for degrees, C for temperature.
// - X tilt fills bytes 2 and 3, magnitude in bits 14 to 0.
// - alarm acts only between control-enable and control-disable commands.
module tilt_alarm_and_report_framer #(
  parameter logic [15:0] FACTORY_ZERO_X = 16'h0000,
  parameter logic [15:0] FACTORY_ZERO_Y = 16'h0000,
  parameter int          DIV_W          = 26
) (
  input  wire logic                   MCLK_I,
  input  wire logic                   RST_B_I,
  input  wire logic [tilt_pkg::AW-1:0] ADDR_I,
  input  wire logic [tilt_pkg::DW-1:0] WDATA_I,
  input  wire logic                   WR_I,
  input  wire logic                   RD_I,
  output logic      [tilt_pkg::DW-1:0] RDATA_O,
  input  wire logic                   SAMPLE_VALID_I,
  input  wire logic [15:0]            SAMPLE_X_I,
  input  wire logic [15:0]            SAMPLE_Y_I,
  input  wire logic [15:0]            SAMPLE_T_I,
  output logic      [7:0]             TX_DATA_O,
  output logic                        TX_VALID_O,
  input  wire logic                   TX_READY_I,
  output logic                        GENERAL_ALARM_OUT_O
);
  import tilt_pkg::*;

  // sums of up to 1000 full-scale samples need 26 bits
  if (DIV_W < 26) begin : g_bad_width
    $error("DIV_W must be at least 26");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_AVG  = 3'h1,
    S_CONV = 3'h2,
    S_TEXT = 3'h3,
    S_BIN  = 3'h4
  } state_e;

  typedef struct packed {
    state_e                 st;
    fmt_e                   fmt;
    fmt_e                   rfmt;
    logic [9:0]             avgn;
    logic [15:0]            hyst;
    logic [15:0]            serial;
    logic [3:0][15:0]       stg;
    logic [3:0][15:0]       lim;
    logic                   ctrl_en;
    logic                   zero_ok;
    logic [1:0][15:0]       zero;
    logic [2:0][DIV_W-1:0]  acc;
    logic [9:0]             cnt;
    logic [2:0][DIV_W-1:0]  snap;
    logic [9:0]             snap_n;
    logic                   avg_pend;
    logic                   rep_pend;
    logic [2:0][15:0]       avg;
    logic [1:0]             ai;
    logic [1:0]             cf;
    logic [2:0]             ck;
    logic [3:0][5:0][3:0]   dig;
    logic [DIV_W-1:0]       cur;
    logic                   div_go;
    logic [5:0]             e_idx;
    logic [2:0]             e_sub;
    logic [7:0]             chk;
    logic                   ck_on;
    logic [7:0]             tx_data;
    logic                   tx_valid;
    logic                   alarm;
    logic [15:0]            rdata;
  } st_s;

  st_s                   s;
  st_s                   next_s;
  logic                  div_done;
  logic [DIV_W-1:0]      div_quo;
  logic [DIV_W-1:0]      div_rem;
  logic [DIV_W-1:0]      div_den;
  logic [2:0][15:0]      smp;
  logic [2:0][DIV_W-1:0] sum;
  logic [1:0]            trip;
  logic [1:0]            calm;
  logic [1:0][15:0]      fzero;

  function automatic logic [15:0] mag16(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [DIV_W-1:0] smag(input logic [DIV_W-1:0] v);
    return v[DIV_W-1] ? DIV_W'(-v) : v;
  endfunction

  // -32768 cannot be shown in 15 bits, so it saturates
  function automatic logic [15:0] sm16(input logic [15:0] v);
    logic [15:0] m;
    m = mag16(v);
    return {v[15], m[15] ? 15'h7FFF : m[14:0]};
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] d);
    return (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
  endfunction

  function automatic logic [5:0] txt_len(input fmt_e f);
    case (f)
      nmea_xdr_format:   return 6'(LEN_XDR);
      alt_nmea_format:   return 6'(LEN_ALT);
      pitch_roll_format: return 6'(LEN_PR);
      default:           return 6'(LEN_SIM);
    endcase
  endfunction

  function automatic logic [7:0] txt_char(input fmt_e f, input logic [5:0] i);
    case (f)
      nmea_xdr_format:   return TXT_XDR[8*(LEN_XDR-1-int'(i)) +: 8];
      alt_nmea_format:   return TXT_ALT[8*(LEN_ALT-1-int'(i)) +: 8];
      pitch_roll_format: return TXT_PR[8*(LEN_PR-1-int'(i)) +: 8];
      default:           return TXT_SIM[8*(LEN_SIM-1-int'(i)) +: 8];
    endcase
  endfunction

  // start value of a text field: x, y, temperature in thousandths, serial as a plain integer
  function automatic logic [DIV_W-1:0] fval(input logic [1:0] f, input logic [2:0][15:0] av,
                                            input logic [15:0] sn);
    logic [26:0] p;
    p = 27'(mag16(av[f[0]])) * 27'(MDEG_Q16);
    case (f)
      2'h0, 2'h1: return DIV_W'(p[26:16]);
      2'h2:       return DIV_W'(mag16(av[2])) << TEMP_SH;
      default:    return DIV_W'(sn);
    endcase
  endfunction

  assign smp   = {SAMPLE_T_I, SAMPLE_Y_I, SAMPLE_X_I};
  assign fzero = {FACTORY_ZERO_Y, FACTORY_ZERO_X};

  for (genvar k = 0; k < 3; k++) begin : g_sum
    assign sum[k] = s.acc[k] + DIV_W'($signed(smp[k]));
  end

  for (genvar a = 0; a < 2; a++) begin : g_axis
    logic signed [17:0] t;
    logic signed [17:0] p;
    logic signed [17:0] n;
    logic signed [17:0] h;
    assign t = 18'($signed(s.avg[a])) -
               18'($signed(s.zero_ok ? s.zero[a] : fzero[a]));
    assign p = 18'($signed(s.lim[2*a]));
    assign n = 18'($signed(s.lim[2*a+1]));
    assign h = $signed({2'h0, s.hyst});
    assign trip[a] = (t > p) || ((n > 0) && (t < n));
    assign calm[a] = (t <= p - h) && ((n <= 0) || (t >= n + h));
  end

  // divide by the sample count while averaging, by ten while making digits
  assign div_den = (s.st == S_AVG) ? DIV_W'(s.snap_n) : DIV_W'(10);

  tilt_divider #(
    .W(DIV_W)
  ) u_div (
    .clk_i   (MCLK_I),
    .rst_b_i (RST_B_I),
    .start_i (s.div_go),
    .num_i   (s.cur),
    .den_i   (div_den),
    .done_o  (div_done),
    .quo_o   (div_quo),
    .rem_o   (div_rem)
  );

  always_comb begin
    logic [7:0] tok;
    logic [7:0] ch;
    logic [7:0] bb;
    logic [2:0] last;
    logic [1:0] f;
    logic       free;
    tok  = txt_char(s.rfmt, s.e_idx);
    ch   = tok;
    bb   = s.chk & CK_MASK;
    last = 3'h0;
    f    = 2'h0;
    free = !s.tx_valid || TX_READY_I;
    next_s = s;
    next_s.div_go = 1'h0;
    next_s.rdata  = 16'h0000;
    if (s.tx_valid && TX_READY_I) begin
      next_s.tx_valid = 1'h0;
    end

    // expand a field marker into its characters
    case (tok)
      PH_X, PH_Y, PH_T: begin
        f    = (tok == PH_X) ? 2'h0 : (tok == PH_Y) ? 2'h1 : 2'h2;
        last = 3'h6;
        case (s.e_sub)
          3'h0:    ch = s.avg[f][15] ? CH_DASH : CH_0 + {4'h0, s.dig[f][5]};
          3'h1:    ch = CH_0 + {4'h0, s.dig[f][4]};
          3'h2:    ch = CH_0 + {4'h0, s.dig[f][3]};
          3'h3:    ch = CH_DOT;
          default: ch = CH_0 + {4'h0, s.dig[f][3'h6 - s.e_sub]};
        endcase
      end
      PH_S: begin
        // only four serial digits fit the field
        last = 3'h4;
        ch   = (s.e_sub == 3'h0) ? CH_N : CH_0 + {4'h0, s.dig[3][3'h4 - s.e_sub]};
      end
      PH_H: begin
        last = 3'h1;
        ch   = (s.e_sub == 3'h0) ? hexc(s.chk[7:4]) : hexc(s.chk[3:0]);
      end
      default: ;
    endcase

    case (s.e_idx)
      6'h00:       bb = SYNC_A;
      6'h01:       bb = SYNC_B;
      6'h02:       bb = sm16(s.avg[0])[15:8];
      6'h03:       bb = sm16(s.avg[0])[7:0];
      6'h04:       bb = sm16(s.avg[1])[15:8];
      6'h05:       bb = sm16(s.avg[1])[7:0];
      6'h06:       bb = sm16(s.avg[2])[15:8];
      6'h07:       bb = sm16(s.avg[2])[7:0];
      6'h08:       bb = s.serial[15:8];
      6'h09:       bb = s.serial[7:0];
      default: ;
    endcase

    case (s.st)
      S_IDLE: begin
        if (s.avg_pend) begin
          next_s.avg_pend = 1'h0;
          next_s.ai       = 2'h0;
          next_s.cur      = smag(s.snap[0]);
          next_s.div_go   = 1'h1;
          next_s.st       = S_AVG;
        end else if (s.rep_pend) begin
          next_s.rep_pend = 1'h0;
          next_s.rfmt     = s.fmt;
          next_s.e_idx    = 6'h00;
          next_s.e_sub    = 3'h0;
          next_s.chk      = 8'h00;
          next_s.ck_on    = 1'h0;
          if (s.fmt == compact_binary_format) begin
            next_s.st = S_BIN;
          end else begin
            next_s.cf     = 2'h0;
            next_s.ck     = 3'h0;
            next_s.cur    = fval(2'h0, s.avg, s.serial);
            next_s.div_go = 1'h1;
            next_s.st     = S_CONV;
          end
        end
      end
      S_AVG: begin
        if (div_done) begin
          next_s.avg[s.ai] = s.snap[s.ai][DIV_W-1] ? 16'(-div_quo) : div_quo[15:0];
          if (s.ai == 2'h2) begin
            next_s.st = S_IDLE;
          end else begin
            next_s.ai     = s.ai + 2'h1;
            next_s.cur    = smag(s.snap[s.ai + 2'h1]);
            next_s.div_go = 1'h1;
          end
        end
      end
      S_CONV: begin
        if (div_done) begin
          next_s.dig[s.cf][s.ck] = div_rem[3:0];
          next_s.div_go = 1'h1;
          if (s.ck != 3'h5) begin
            next_s.ck  = s.ck + 3'h1;
            next_s.cur = div_quo;
          end else if (s.cf != 2'h3) begin
            next_s.cf  = s.cf + 2'h1;
            next_s.ck  = 3'h0;
            next_s.cur = fval(s.cf + 2'h1, s.avg, s.serial);
          end else begin
            next_s.div_go = 1'h0;
            next_s.st     = S_TEXT;
          end
        end
      end
      S_TEXT: begin
        if (free) begin
          next_s.tx_data  = ch;
          next_s.tx_valid = 1'h1;
          if (tok == CH_STAR) begin
            next_s.ck_on = 1'h0;
          end else if (s.ck_on) begin
            next_s.chk = s.chk ^ ch;
          end
          if (s.e_idx == 6'h00) begin
            next_s.ck_on = 1'h1;
          end
          if (s.e_sub == last) begin
            next_s.e_sub = 3'h0;
            if (s.e_idx == txt_len(s.rfmt) - 6'h01) begin
              next_s.st = S_IDLE;
            end else begin
              next_s.e_idx = s.e_idx + 6'h01;
            end
          end else begin
            next_s.e_sub = s.e_sub + 3'h1;
          end
        end
      end
      S_BIN: begin
        if (free) begin
          next_s.tx_data  = bb;
          next_s.tx_valid = 1'h1;
          if (s.e_idx >= 6'h02 && s.e_idx <= 6'h07) begin
            next_s.chk = s.chk + bb;
          end
          if (s.e_idx == BIN_LAST) begin
            next_s.st = S_IDLE;
          end else begin
            next_s.e_idx = s.e_idx + 6'h01;
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase

    // a window ending during averaging overwrites the snapshot; samples are slow
    if (SAMPLE_VALID_I) begin
      if (s.cnt + 10'h001 >= s.avgn) begin
        next_s.snap     = sum;
        next_s.snap_n   = s.cnt + 10'h001;
        next_s.avg_pend = 1'h1;
        next_s.acc      = '0;
        next_s.cnt      = 10'h000;
      end else begin
        next_s.acc = sum;
        next_s.cnt = s.cnt + 10'h001;
      end
    end

    // settings change only on explicit writes
    if (WR_I) begin
      case (ADDR_I)
        A_CMD: begin
          if (WDATA_I[CMD_LIMITS]) begin
            next_s.lim = s.stg;
          end
          if (WDATA_I[CMD_ZERO]) begin
            next_s.zero    = s.avg[1:0];
            next_s.zero_ok = 1'h1;
          end
          if (WDATA_I[CMD_FZERO]) begin
            next_s.zero_ok = 1'h0;
          end
          if (WDATA_I[CMD_READ]) begin
            next_s.rep_pend = 1'h1;
          end
          if (WDATA_I[CMD_ON]) begin
            next_s.ctrl_en = 1'h1;
          end
          if (WDATA_I[CMD_OFF]) begin
            next_s.ctrl_en = 1'h0;
          end
        end
        A_FMT: begin
          if (WDATA_I <= 16'(compact_binary_format)) begin
            next_s.fmt = fmt_e'(WDATA_I[2:0]);
          end
        end
        A_AVGN: begin
          if (WDATA_I != 16'h0000 && WDATA_I <= AVGN_MAX) begin
            next_s.avgn = WDATA_I[9:0];
          end
        end
        A_HYST: next_s.hyst = WDATA_I;
        A_XP, A_XN, A_YP, A_YN: next_s.stg[ADDR_I[1:0]] = WDATA_I;
        A_SER:  next_s.serial = WDATA_I;
        default: ;
      endcase
    end

    if (RD_I) begin
      case (ADDR_I)
        A_FMT:  next_s.rdata = 16'(s.fmt);
        A_AVGN: next_s.rdata = 16'(s.avgn);
        A_HYST: next_s.rdata = s.hyst;
        A_XP, A_XN, A_YP, A_YN: next_s.rdata = s.lim[ADDR_I[1:0]];
        A_SER:  next_s.rdata = s.serial;
        A_STAT: next_s.rdata = 16'({s.st != S_IDLE || s.rep_pend, s.zero_ok,
                                    s.ctrl_en, s.alarm});
        A_AVX:  next_s.rdata = s.avg[0];
        A_AVY:  next_s.rdata = s.avg[1];
        A_AVT:  next_s.rdata = s.avg[2];
        default: next_s.rdata = 16'h0000;
      endcase
    end

    // hold until every axis is back inside its band
    next_s.alarm = s.ctrl_en && (s.alarm ? !(&calm) : (|trip));
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s      <= '0;
      s.avgn <= AVGN_RST;
      s.hyst <= HYST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA_O             = s.rdata;
  assign TX_DATA_O           = s.tx_data;
  assign TX_VALID_O          = s.tx_valid;
  assign GENERAL_ALARM_OUT_O = s.alarm;
endmodule

/* sim/tilt_assertions.sv */
// checker: settings readback, alarm gating, report frame layout
// assumes binding to the framer top; sees its ports only
`timescale 1ns/1ps
module tilt_checker (
  input wire logic                    MCLK_I,
  input wire logic                    RST_B_I,
  input wire logic [tilt_pkg::AW-1:0] ADDR_I,
  input wire logic [tilt_pkg::DW-1:0] WDATA_I,
  input wire logic                    WR_I,
  input wire logic                    RD_I,
  input wire logic [tilt_pkg::DW-1:0] RDATA_O,
  input wire logic [7:0]              TX_DATA_O,
  input wire logic                    TX_VALID_O,
  input wire logic                    TX_READY_I,
  input wire logic                    GENERAL_ALARM_OUT_O
);
  import tilt_pkg::*;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  logic       hs, b, t, en;
  logic [2:0] fmt, lat, cur;
  logic [5:0] cnt;
  logic [7:0] sum;
  logic [9:0] avg;
  assign hs  = TX_VALID_O && TX_READY_I;
  assign cur = (cnt == 6'h00) ? fmt : lat;
  assign b   = hs && cur == 3'h4;
  assign t   = hs && cur != 3'h4;
  // shadows of settings; rejected writes leave them alone
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fmt <= 3'h0;
      lat <= 3'h0;
      cnt <= 6'h00;
      sum <= 8'h00;
      avg <= AVGN_RST;
      en  <= 1'b0;
    end else begin
      if (WR_I && ADDR_I == A_FMT && WDATA_I <= 16'h0004) fmt <= WDATA_I[2:0];
      if (WR_I && ADDR_I == A_AVGN && WDATA_I != 16'h0000 && WDATA_I <= AVGN_MAX) avg <= WDATA_I[9:0];
      if (WR_I && ADDR_I == A_CMD && (WDATA_I[3] || WDATA_I[4])) en <= !WDATA_I[4];
      if (hs) begin
        lat <= cur;
        // text frames end on line feed, binary ones by count
        if (cur == 3'h4) cnt <= (cnt == 6'h0A) ? 6'h00 : cnt + 6'h01;
        else cnt <= (TX_DATA_O == 8'h0A) ? 6'h00 : cnt + 6'h01;
        if (cnt < 6'h02) sum <= 8'h00;
        else if (cnt < 6'h08) sum <= sum + TX_DATA_O;
      end
    end
  end
  a_sync_first: assert property (
    b && cnt == 6'h00 |-> TX_DATA_O == SYNC_A) else $error("bad first sync byte");
  a_sync_second: assert property (
    b && cnt == 6'h01 |-> TX_DATA_O == SYNC_B) else $error("bad second sync byte");
  a_text_start: assert property (
    t && cnt == 6'h00 |-> TX_DATA_O == 8'h24) else $error("text report lacks dollar");
  a_bin_sum: assert property (
    b && cnt == 6'h0A |-> TX_DATA_O == (sum & CK_MASK)) else $error("bad frame checksum");
  a_byte_hold: assert property (
    TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O)) else $error("byte dropped");
  a_alarm_gated: assert property (
    !en && !$past(en) |-> !GENERAL_ALARM_OUT_O) else $error("alarm while disabled");
  a_alarm_needs_en: assert property (
    $rose(GENERAL_ALARM_OUT_O) |-> en || $past(en)) else $error("alarm rose while disabled");
  a_fmt_kept: assert property (
    RD_I && ADDR_I == A_FMT |=> RDATA_O == {13'h0000, fmt}) else $error("format not kept");
  a_count_kept: assert property (
    RD_I && ADDR_I == A_AVGN |=> RDATA_O == {6'h00, avg}) else $error("count not kept");
  c_bin_done: cover property (b && cnt == 6'h0A);
  c_alarm_up: cover property ($rose(GENERAL_ALARM_OUT_O));
  c_stall: cover property (TX_VALID_O && !TX_READY_I);
endmodule
bind tilt_alarm_and_report_framer tilt_checker u_chk (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I),
  .GENERAL_ALARM_OUT_O(GENERAL_ALARM_OUT_O));

/* sim/tx_sink_model.sv */
// host side of the report stream: takes and keeps every byte
// assumes the framer clock; slow mode stalls two cycles in three
`timescale 1ns/1ps
module tx_sink_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       slow_i,
  output logic            ready_o
);
  logic [7:0] got[$];
  logic [1:0] ph;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph      <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      ph      <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      ready_o <= !slow_i || (ph == 2'h2);
      if (valid_i && ready_o) got.push_back(data_i);
    end
  end
endmodule

/* sim/tb_top.sv */
// bench for the tilt framer: register port, samples, alarm, reports
// assumes the package, the sink model and the checker compile first
`timescale 1ns/1ps
module tb_top;
  import tilt_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, sv = 1'b0, slow = 1'b0;
  logic ready, valid, alarm;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, sx = 16'h0000, sy = 16'h0000, st = 16'h0000, rdata;
  logic [7:0] txd, x;
  int miscompares = 0, n_compared = 0, n;
  int len_t[4] = '{32, 59, 60, 22};
  int pos_t[4] = '{8, 17, 21, 1};
  logic [7:0] ch_t[4] = '{8'h2C, 8'h44, 8'h44, 8'h50};
  logic [7:0] exp_b[11] = '{8'h55, 8'hAA, 8'h00, 8'h0F, 8'h80, 8'h03, 8'h00, 8'h64, 8'h12,
    8'h34, 8'hF6};
  tilt_alarm_and_report_framer u_dut (.MCLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SAMPLE_VALID_I(sv),
    .SAMPLE_X_I(sx), .SAMPLE_Y_I(sy), .SAMPLE_T_I(st), .TX_DATA_O(txd), .TX_VALID_O(valid),
    .TX_READY_I(ready), .GENERAL_ALARM_OUT_O(alarm));
  tx_sink_model u_sink (.clk_i(clk), .rst_b_i(rst_b), .valid_i(valid), .data_i(txd),
    .slow_i(slow), .ready_o(ready));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input bit poll);
    logic [15:0] d;
    // polling covers the averaging delay, bounded
    for (int i = 0; i < (poll ? 300 : 1); i++) begin
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
      if (d === e) break;
    end
    chk(d, e);
    if (d !== e && poll) complete_run();
  endtask
  task automatic sample(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk);
    sx <= a;
    sy <= b;
    st <= c;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
  endtask
  task automatic alarm_is(input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, alarm}, {15'h0000, e});
  endtask
  task automatic report(input logic [2:0] f, input int len, input int reqs);
    u_sink.got.delete();
    wr_reg(A_FMT, {13'h0000, f});
    repeat (reqs) wr_reg(A_CMD, 16'h0004);
    for (int i = 0; i < 20000 && u_sink.got.size() < len * reqs; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    chk(16'(u_sink.got.size()), 16'(len * reqs));
    if (u_sink.got.size() != len * reqs) complete_run();
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(A_FMT, 16'h0000, 0);
    rd_chk(A_HYST, 16'h0000, 0);
    rd_chk(A_STAT, 16'h0000, 0);
    rd_chk(4'hD, 16'h0000, 0);
    wr_reg(A_FMT, 16'h0005);
    wr_reg(A_AVGN, 16'h0000);
    rd_chk(A_FMT, 16'h0000, 0);
    rd_chk(A_AVGN, 16'h0001, 0);
    wr_reg(A_AVGN, 16'h0002);
    wr_reg(A_SER, 16'h1234);
    rd_chk(A_SER, 16'h1234, 0);
    sample(16'h000A, 16'hFFFD, 16'h0064);
    sample(16'h0014, 16'hFFFC, 16'h0065);
    rd_chk(A_AVX, 16'h000F, 1);
    rd_chk(A_AVY, 16'hFFFD, 1);
    rd_chk(A_AVT, 16'h0064, 1);
    // two requests back to back under a stalling sink: second one queued
    slow <= 1'b1;
    report(3'h4, 11, 2);
    for (int i = 0; i < 22; i++) begin
      chk(u_sink.got[i], exp_b[i % 11]);
    end
    slow <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      report(3'(f), len_t[f], 1);
      n = len_t[f];
      chk(u_sink.got[0], 8'h24);
      chk({u_sink.got[n-2], u_sink.got[n-1]}, 16'h0D0A);
      chk(u_sink.got[pos_t[f]], ch_t[f]);
      if (f == 2) chk(u_sink.got[n-7], CH_N);
      if (f == 1 || f == 3) begin
        x = 8'h00;
        for (int i = 1; i < n - 5; i++) x ^= u_sink.got[i];
        chk({u_sink.got[n-4], u_sink.got[n-3]}, {hx(x[7:4]), hx(x[3:0])});
      end
    end
    wr_reg(A_XP, 16'h0064);
    wr_reg(A_YP, 16'h0064);
    wr_reg(A_CMD, 16'h0001);
    rd_chk(A_XP, 16'h0064, 0);
    wr_reg(A_CMD, 16'h0008);
    alarm_is(1'b0);
    wr_reg(A_YN, 16'h0001);
    rd_chk(A_YN, 16'h0000, 0);
    wr_reg(A_CMD, 16'h0001);
    alarm_is(1'b1);
    wr_reg(A_YN, 16'h0000);
    wr_reg(A_XP, 16'h000A);
    wr_reg(A_CMD, 16'h0001);
    alarm_is(1'b1);
    wr_reg(A_HYST, 16'h000A);
    wr_reg(A_XP, 16'h000F);
    wr_reg(A_CMD, 16'h0001);
    alarm_is(1'b1);
    wr_reg(A_XP, 16'h0064);
    wr_reg(A_CMD, 16'h0001);
    alarm_is(1'b0);
    wr_reg(A_XP, 16'h000A);
    wr_reg(A_CMD, 16'h0001);
    alarm_is(1'b1);
    wr_reg(A_CMD, 16'h0002);
    alarm_is(1'b0);
    rd_chk(A_STAT, 16'h0006, 0);
    wr_reg(A_CMD, 16'h0020);
    alarm_is(1'b1);
    wr_reg(A_CMD, 16'h0018);
    alarm_is(1'b0);
    rd_chk(A_STAT, 16'h0000, 0);
    complete_run();
  end
endmodule
